// ---- pkg/rtf_pkg.sv ----
// Constants for the reset sequencer and its cause-flag registers.
// Assumes a 100 MHz system clock and an AXI4-Lite register bus.
`default_nettype none
package rtf_pkg;
    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [7:0] ADDR_CAUSE = 8'h00;
    localparam logic [7:0] ADDR_STACK = 8'h04;
    localparam logic [7:0] ADDR_CFG2L = 8'h08;
    localparam logic [7:0] ADDR_CFG2H = 8'h0C;
    localparam logic [7:0] ADDR_CFG3H = 8'h10;
    localparam logic [7:0] ADDR_CFG4L = 8'h14;
    localparam logic [7:0] ADDR_EVENT = 8'h18;
    localparam logic [7:0] ADDR_PC = 8'h1C;
    localparam logic [7:0] ADDR_SEQ = 8'h20;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int CAUSE_IRQPRI = 7;
    localparam int CAUSE_SBOR = 6;
    localparam int CAUSE_RSTI = 4;
    localparam int CAUSE_TMO = 3;
    localparam int CAUSE_PDN = 2;
    localparam int CAUSE_POR = 1;
    localparam int CAUSE_BRN = 0;
    localparam int STK_FULL = 7;
    localparam int STK_UNF = 6;
    localparam int CFG2L_PUT_DIS = 0;
    localparam int CFG4L_STOVR = 0;
    // Event register bits (write one to trigger)
    localparam int EV_POR = 0;
    localparam int EV_BRN = 1;
    localparam int EV_RSTI = 2;
    localparam int EV_WDG = 3;
    localparam int EV_SFULL = 4;
    localparam int EV_SUNF = 5;
    localparam int EV_IRQW = 6;
    localparam int EV_PMEXIT = 7;
    // ****************************************
    // Masks and reset values
    // ****************************************
    localparam logic [7:0] CAUSE_MASK = 8'hDF;
    localparam logic [7:0] STK_MASK = 8'hDF;
    localparam logic [7:0] CFG2L_MASK = 8'h1F;
    localparam logic [7:0] CFG2H_MASK = 8'h3F;
    localparam logic [7:0] CFG3H_MASK = 8'hBF;
    localparam logic [7:0] CFG4L_MASK = 8'hC5;
    localparam logic [7:0] CFG2L_RST = 8'h1F;
    localparam logic [7:0] CFG2H_RST = 8'h3F;
    localparam logic [7:0] CFG3H_RST = 8'hBF;
    localparam logic [7:0] CFG4L_RST = 8'h85;
    localparam logic [1:0] BRN_SW = 2'b01;
    localparam logic [20:0] PC_RESET = 21'h00_0000;
    localparam logic [20:0] VEC_HIGH = 21'h00_0008;
    localparam logic [20:0] VEC_LOW = 21'h00_0018;
    localparam logic [20:0] PC_STEP = 21'h00_0002;
    // ****************************************
    // Oscillator modes and run modes
    // ****************************************
    localparam logic [2:0] OSC_XLO = 3'h0;
    localparam logic [2:0] OSC_XMD = 3'h1;
    localparam logic [2:0] OSC_XHI = 3'h2;
    localparam logic [2:0] OSC_XMUL = 3'h3;
    localparam logic [2:0] OSC_EXT = 3'h4;
    localparam logic [2:0] OSC_RCO = 3'h5;
    localparam logic [2:0] OSC_INT = 3'h6;
    localparam logic [1:0] RUN_FULL = 2'h0;
    localparam logic [1:0] RUN_PM = 2'h1;
    localparam logic [1:0] RUN_IDLE = 2'h2;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ = 100;
    localparam int START_CYC = 1024;
    localparam int LOCK_US = 2000;
    localparam int LOCK_CYC = LOCK_US * CLK_MHZ;
    localparam int PUT_US = 65500;
    localparam int PUT_CYC = PUT_US * CLK_MHZ;
    localparam int CNT_W = 24;
    typedef enum logic [2:0] {
        RTF_IDLE, RTF_PUT, RTF_START, RTF_LOCK, RTF_HOLD, RTF_RUN
    } rtf_state_e;
endpackage
`default_nettype wire

// ---- src/rtf_reset_seq.sv ----
// Reset release sequencer with reset-cause and stack status flags.
// Assumes AXI4-Lite master on sys_clk, pins from outside the domain.
// Behaviour
// - After power-up timer, hold reset 1024 more oscillator input cycles.
// - Start-up count only in crystal modes, on power-on or oscillator-stop exit.
// - With multiplier enabled, wait 2 ms lock after start-up count.
// - Power-up timer starts after power-on pulse; start-up count follows it.
// - Resistor-capacitor mode without power-up timer: release when pulse ends.
// - Time-outs run regardless of reset pin; release instantly after pin rises.
// - Power-up timer 65.5 ms only on power-up when its disable bit clear.
// - Multiplier mode: start-up count plus lock wait on power-up and exit.
// - Some registers untouched by any reset; unknown after power-on.
// - Watchdog wake-up resumes operation, registers mostly unchanged.
// - Power-on, brown-out and reset-instruction flag updates and pc zero.
// - Pin reset in managed run sets timeout; idle/sleep also clears powerdown.
// - Watchdog in run: pc zero, clear timeout flag only.
// - Pin reset in full power: pc zero, flags unchanged.
// - Stack-full reset with option set: set full flag, pc zero.
// - Underflow sets flag, pc zero; real reset only with option set.
// - Watchdog in idle/sleep: pc plus two, clear timeout and powerdown.
// - Interrupt wake clears powerdown; pc plus two or interrupt vector.
// - Software brown-out enable: set by power-on if field is 01, else 0.
// - Unimplemented register bits read as zero.
// - Power-on flag cleared only by power-on; software sets it back.
// - Clear disable bit to enable power-up timer; reset held meanwhile.
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`default_nettype none
module rtf_reset_seq
    import rtf_pkg::*;
#(
    parameter int PUT_COUNT = PUT_CYC,
    parameter int LOCK_COUNT = LOCK_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic power_on_pulse,
    input wire logic external_reset_pin_n,
    input wire logic osc_in,
    input wire logic [2:0] osc_mode,
    input wire logic [1:0] run_mode,
    input wire logic global_irq_enable_high,
    input wire logic global_irq_enable_low,
    input wire logic [20:0] pc_current,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic core_reset,
    output logic [20:0] pc_load,
    output logic pc_load_valid
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] por_sy_reg, pin_sy_reg, osc_sy_reg;
    logic por_reg, pin_reg, osc_reg;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            por_sy_reg <= 3'h7;
            pin_sy_reg <= 3'h0;
            osc_sy_reg <= 3'h0;
        end else begin
            por_sy_reg <= {por_sy_reg[1:0], power_on_pulse};
            pin_sy_reg <= {pin_sy_reg[1:0], external_reset_pin_n};
            osc_sy_reg <= {osc_sy_reg[1:0], osc_in};
        end
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            por_reg <= 1'b1;
            pin_reg <= 1'b0;
            osc_reg <= 1'b0;
        end else begin
            if (por_sy_reg[2] == por_sy_reg[1]) por_reg <= por_sy_reg[2];
            if (pin_sy_reg[2] == pin_sy_reg[1]) pin_reg <= pin_sy_reg[2];
            if (osc_sy_reg[2] == osc_sy_reg[1]) osc_reg <= osc_sy_reg[2];
        end
    end
    logic osc_prev_reg;
    logic osc_rise;
    always_ff @(posedge sys_clk) begin
        if (srst) osc_prev_reg <= 1'b0;
        else osc_prev_reg <= osc_reg;
    end
    assign osc_rise = osc_reg & ~osc_prev_reg;
    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] cause_reg, stack_reg, cfg2l_reg, cfg2h_reg;
    logic [7:0] cfg3h_reg, cfg4l_reg;
    logic [7:0] ev_pulse;
    logic wr_fire, rd_fire;
    logic [7:0] aw_reg;
    logic [31:0] wd_reg;
    logic [3:0] ws_reg;
    logic aw_have_reg, w_have_reg;
    logic crystal, put_on, is_pll, por_fall;
    logic [CNT_W-1:0] cnt_reg;
    rtf_state_e state_reg;
    logic por_prev_reg;
    logic pm_exit_pend_reg;
    // ****************************************
    // Write channel
    // ****************************************
    assign s_axi_awready = ~aw_have_reg & ~s_axi_bvalid;
    assign s_axi_wready = ~w_have_reg & ~s_axi_bvalid;
    assign s_axi_bresp = 2'b00;
    assign wr_fire = aw_have_reg & w_have_reg & ~s_axi_bvalid;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_reg <= 8'h00;
            wd_reg <= 32'h0000_0000;
            ws_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                wd_reg <= s_axi_wdata;
                ws_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    logic wr_lane0;
    assign wr_lane0 = wr_fire & ws_reg[0];
    assign ev_pulse = (wr_lane0 && aw_reg == ADDR_EVENT) ? wd_reg[7:0] : 8'h00;
    // ****************************************
    // Configuration registers, kept over all resets except srst
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (wr_lane0 && aw_reg == ADDR_CFG2L)
            cfg2l_reg <= wd_reg[7:0] & CFG2L_MASK;
        if (wr_lane0 && aw_reg == ADDR_CFG2H)
            cfg2h_reg <= wd_reg[7:0] & CFG2H_MASK;
        if (wr_lane0 && aw_reg == ADDR_CFG3H)
            cfg3h_reg <= wd_reg[7:0] & CFG3H_MASK;
        if (wr_lane0 && aw_reg == ADDR_CFG4L)
            cfg4l_reg <= wd_reg[7:0] & CFG4L_MASK;
        if (srst) begin
            cfg2l_reg <= CFG2L_RST;
            cfg2h_reg <= CFG2H_RST;
            cfg3h_reg <= CFG3H_RST;
            cfg4l_reg <= CFG4L_RST;
        end
    end
    // ****************************************
    // Cause and stack flags
    // ****************************************
    logic stovr, sbor_avail, idle_run, unf_reset, pin_rst;
    assign stovr = cfg4l_reg[CFG4L_STOVR];
    assign sbor_avail = cfg2l_reg[2:1] == BRN_SW;
    assign idle_run = run_mode == RUN_IDLE;
    assign pin_rst = (state_reg == RTF_RUN) & ~pin_reg;
    always_ff @(posedge sys_clk) begin
        if (wr_lane0 && aw_reg == ADDR_CAUSE)
            cause_reg <= wd_reg[7:0] & CAUSE_MASK &
                {1'b1, sbor_avail, 6'h3F};
        if (wr_lane0 && aw_reg == ADDR_STACK)
            stack_reg <= wd_reg[7:0] & STK_MASK;
        if (ev_pulse[EV_BRN]) begin
            cause_reg[CAUSE_RSTI] <= 1'b1;
            cause_reg[CAUSE_TMO] <= 1'b1;
            cause_reg[CAUSE_PDN] <= 1'b1;
            cause_reg[CAUSE_BRN] <= 1'b0;
        end
        if (ev_pulse[EV_RSTI]) cause_reg[CAUSE_RSTI] <= 1'b0;
        if (pin_rst && run_mode != RUN_FULL) begin
            cause_reg[CAUSE_TMO] <= 1'b1;
            if (idle_run) cause_reg[CAUSE_PDN] <= 1'b0;
        end
        if (ev_pulse[EV_WDG]) begin
            cause_reg[CAUSE_TMO] <= 1'b0;
            if (idle_run) cause_reg[CAUSE_PDN] <= 1'b0;
        end
        if (ev_pulse[EV_IRQW]) cause_reg[CAUSE_PDN] <= 1'b0;
        if (ev_pulse[EV_SFULL] && stovr) stack_reg[STK_FULL] <= 1'b1;
        if (ev_pulse[EV_SUNF]) stack_reg[STK_UNF] <= 1'b1;
        if (srst || por_fall) begin
            cause_reg <= {1'b0, sbor_avail, 1'b0, 3'h7, 2'b00};
            stack_reg[STK_FULL] <= 1'b0;
            stack_reg[STK_UNF] <= 1'b0;
            stack_reg[5:0] <= 6'h00;
        end else if (ev_pulse[EV_POR]) begin
            cause_reg <= {1'b0, sbor_avail, 1'b0, 3'h7, 2'b00};
            stack_reg <= 8'h00;
        end else if (|ev_pulse[5:0] || core_reset) begin
            if (!sbor_avail) cause_reg[CAUSE_SBOR] <= 1'b0;
            stack_reg[4:0] <= 5'h00;
        end
    end
    // ****************************************
    // Program counter load
    // ****************************************
    assign unf_reset = ev_pulse[EV_SUNF] & stovr;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pc_load <= PC_RESET;
            pc_load_valid <= 1'b0;
        end else begin
            pc_load_valid <= |ev_pulse[6:0] | por_fall | pin_rst;
            if (ev_pulse[EV_IRQW]) begin
                if (global_irq_enable_high) pc_load <= VEC_HIGH;
                else if (global_irq_enable_low) pc_load <= VEC_LOW;
                else pc_load <= pc_current + PC_STEP;
            end else if (ev_pulse[EV_WDG] && idle_run) begin
                pc_load <= pc_current + PC_STEP;
            end else if (|ev_pulse[5:0] || por_fall || pin_rst) begin
                pc_load <= PC_RESET;
            end
        end
    end
    // ****************************************
    // Time-out sequencer
    // ****************************************
    assign crystal = osc_mode <= OSC_XMUL;
    assign is_pll = osc_mode == OSC_XMUL;
    assign put_on = ~cfg2l_reg[CFG2L_PUT_DIS];
    always_ff @(posedge sys_clk) begin
        if (srst) por_prev_reg <= 1'b1;
        else por_prev_reg <= por_reg;
    end
    assign por_fall = por_prev_reg & ~por_reg;
    always_ff @(posedge sys_clk) begin
        if (srst) pm_exit_pend_reg <= 1'b0;
        else pm_exit_pend_reg <= ev_pulse[EV_PMEXIT] & crystal;
    end
    always_ff @(posedge sys_clk) begin
        if (srst || por_reg) begin
            state_reg <= RTF_IDLE;
            cnt_reg <= '0;
        end else begin
            case (state_reg)
                RTF_IDLE: begin
                    if (por_fall) begin
                        cnt_reg <= '0;
                        if (put_on) state_reg <= RTF_PUT;
                        else if (crystal) state_reg <= RTF_START;
                        else state_reg <= RTF_HOLD;
                    end
                end
                RTF_PUT: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == CNT_W'(PUT_COUNT - 1)) begin
                        cnt_reg <= '0;
                        state_reg <= crystal ? RTF_START : RTF_HOLD;
                    end
                end
                RTF_START: begin
                    if (osc_rise) cnt_reg <= cnt_reg + 1'b1;
                    if (osc_rise && cnt_reg == CNT_W'(START_CYC - 1)) begin
                        cnt_reg <= '0;
                        state_reg <= is_pll ? RTF_LOCK : RTF_HOLD;
                    end
                end
                RTF_LOCK: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == CNT_W'(LOCK_COUNT - 1)) begin
                        cnt_reg <= '0;
                        state_reg <= RTF_HOLD;
                    end
                end
                RTF_HOLD: begin
                    if (pin_reg) state_reg <= RTF_RUN;
                end
                RTF_RUN: begin
                    if (pm_exit_pend_reg) begin
                        cnt_reg <= '0;
                        state_reg <= RTF_START;
                    end else if (!pin_reg || unf_reset ||
                                 (ev_pulse[EV_SFULL] && stovr)) begin
                        state_reg <= RTF_HOLD;
                    end
                end
                default: state_reg <= RTF_IDLE;
            endcase
        end
    end
    assign core_reset = state_reg != RTF_RUN;
    // ****************************************
    // Read channel
    // ****************************************
    logic [31:0] rd_mux;
    logic rd_ok;
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            ADDR_CAUSE: rd_mux[7:0] = cause_reg;
            ADDR_STACK: rd_mux[7:0] = stack_reg;
            ADDR_CFG2L: rd_mux[7:0] = cfg2l_reg;
            ADDR_CFG2H: rd_mux[7:0] = cfg2h_reg;
            ADDR_CFG3H: rd_mux[7:0] = cfg3h_reg;
            ADDR_CFG4L: rd_mux[7:0] = cfg4l_reg;
            ADDR_EVENT: rd_mux = 32'h0000_0000;
            ADDR_PC: rd_mux[20:0] = pc_load;
            ADDR_SEQ: rd_mux[3:0] = {core_reset, state_reg};
            default: rd_ok = 1'b0;
        endcase
    end
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_fire = s_axi_arvalid & s_axi_arready;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/rtf_reset_seq_properties.sv ----
// Checker for the reset sequencer outputs and its register bus.
// Assumes a bind onto rtf_reset_seq, one clock, srst synchronous.
`default_nettype none
module rtf_reset_seq_checker (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic power_on_pulse,
    input wire logic external_reset_pin_n,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic core_reset,
    input wire logic pc_load_valid
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    a_por_holds: assert property (
        power_on_pulse [*5] |=> core_reset)
        else $error("core released during power-on pulse");
    a_pin_holds: assert property (
        !external_reset_pin_n [*5] |=> core_reset)
        else $error("core released while reset pin low");
    a_release_cause: assert property (
        $fell(core_reset) |->
            $past(external_reset_pin_n, 2) && !$past(power_on_pulse, 2))
        else $error("release without pin high and pulse ended");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_write_single: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("extra write response");
    a_write_block: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_read_block: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_read_unmapped: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h23 |=>
            s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    c_release: cover property ($fell(core_reset));
    c_pc_load: cover property (pc_load_valid);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_refused: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule
bind rtf_reset_seq rtf_reset_seq_checker rtf_reset_seq_checker_inst (
    .sys_clk, .srst, .power_on_pulse, .external_reset_pin_n, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .core_reset, .pc_load_valid
);
`default_nettype wire

// ---- testbench/rtf_far_side.sv ----
// Far-side model: free-running crystal on osc_in and the reset pin.
// Assumes the bench commands pin_hold from its sys_clk process.
`default_nettype none
module rtf_far_side (
    input wire logic pin_hold,
    output logic osc_in,
    output logic external_reset_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Oscillator and pulled-up pin
    // ****************************************
    initial begin
        osc_in = 1'b0;
        #13;
        forever #40 osc_in = ~osc_in;
    end
    assign external_reset_pin_n = ~pin_hold;
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Bench: release timing, cause flags, program counter, register bus.
// Assumes rtf_pkg, the far-side model and the bound checker.
`default_nettype none
module tb_top
    import rtf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PUT_T = 20, LOCK_T = 10, OSC_PER = 8;
    logic sys_clk, srst, power_on_pulse, pin_hold, osc_in;
    logic external_reset_pin_n, core_reset, gie_h, gie_l;
    logic [2:0] osc_mode;
    logic [1:0] run_mode, bresp, rresp, rd_r;
    logic [20:0] pc_current;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_v;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [15:0] flags;
    bit p;
    int n_errors = 0, total_checks = 0, cyc = 0;
    int rel, ev, e;
    rtf_reset_seq #(.PUT_COUNT(PUT_T), .LOCK_COUNT(LOCK_T))
    rtf_reset_seq_inst (
        .sys_clk, .srst, .power_on_pulse, .external_reset_pin_n, .osc_in,
        .osc_mode, .run_mode, .global_irq_enable_high(gie_h),
        .global_irq_enable_low(gie_l), .pc_current, .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .core_reset, .pc_load(), .pc_load_valid()
    );
    rtf_far_side rtf_far_side_inst (.pin_hold, .osc_in, .external_reset_pin_n);
    // ****************************************
    // Clock, timeout, tasks
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int n, input int lo, input int hi);
        total_checks++;
        if (n < lo || n > hi) begin
            n_errors++;
            $display("mismatch at %0t: %0d cycles", $time, n);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk_val({30'h0, bresp}, 32'h0000_0000);
        bready <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd_v = rdata;
        rd_r = rresp;
        rready <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic power_up(input logic [2:0] m, input bit pw, input bit hold);
        srst <= 1'b1;
        power_on_pulse <= 1'b1;
        osc_mode <= m;
        pin_hold <= hold;
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        wr(ADDR_CFG2L, {3'b000, 2'b11, BRN_SW, ~pw});
        power_on_pulse <= 1'b0;
    endtask
    task automatic wait_rel();
        rel = 0;
        do begin
            @(posedge sys_clk);
            rel++;
        end while (core_reset !== 1'b0);
    endtask
    task automatic flag_check();
        rd(ADDR_CAUSE);
        chk_val(rd_v & 32'h0000_00FF, {24'h00_0000, flags[7:0]});
        rd(ADDR_STACK);
        chk_val(rd_v & 32'h0000_00E0, {24'h00_0000, flags[15:8]});
    endtask
    function automatic int exp_rel(input logic [2:0] m, input bit pw);
        exp_rel = (pw ? PUT_T : 0) + (m <= OSC_XMUL ? START_CYC * OSC_PER : 0)
            + (m == OSC_XMUL ? LOCK_T : 0);
    endfunction
    function automatic logic [20:0] exp_pc(input int x);
        if (x == EV_IRQW && (gie_h | gie_l)) return gie_h ? VEC_HIGH : VEC_LOW;
        if ((x == EV_WDG && run_mode == RUN_IDLE) || x == EV_IRQW) begin
            return pc_current + PC_STEP;
        end
        return PC_RESET;
    endfunction
    function automatic logic [15:0] step(input logic [15:0] s, input int x);
        case (x)
            EV_POR: s = 16'h005C;
            EV_BRN: s[4:0] = {3'b111, s[1], 1'b0};
            EV_RSTI: s[4] = 1'b0;
            EV_WDG: s[3:2] = {1'b0, run_mode == RUN_IDLE ? 1'b0 : s[2]};
            EV_SFULL: s[15] = 1'b1;
            EV_SUNF: s[14] = 1'b1;
            EV_IRQW: s[2] = 1'b0;
            default: s[3:2] = {run_mode == RUN_FULL ? s[3] : 1'b1,
                run_mode == RUN_IDLE ? 1'b0 : s[2]};
        endcase
        return s;
    endfunction
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {srst, power_on_pulse, pin_hold, osc_mode} = 6'b110_101;
        {run_mode, pc_current, awaddr, araddr, wdata, gie_h, gie_l} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        rel = $urandom(32'hd0de_2a2f);
        for (int m = 0; m < 7; m++) begin
            p = m == OSC_XMUL ? 1'b1 : m == OSC_RCO ? 1'b0 : 1'($urandom);
            power_up(3'(m), p, 1'b0);
            wait_rel();
            e = exp_rel(3'(m), p);
            chk_rng(rel, e - 8, e + 24);
        end
        power_up(OSC_XMD, 1'b0, 1'b0);
        wait_rel();
        wr(ADDR_EVENT, 8'(1 << EV_PMEXIT));
        while (core_reset !== 1'b1) @(posedge sys_clk);
        wait_rel();
        e = exp_rel(OSC_XMD, 1'b0);
        chk_rng(rel, e - 16, e + 8);
        $display("test release timing done");
        power_up(OSC_RCO, 1'b1, 1'b1);
        repeat (300) @(posedge sys_clk);
        chk_val({31'h0, core_reset}, 32'h0000_0001);
        pin_hold <= 1'b0;
        wait_rel();
        chk_rng(rel, 1, 8);
        $display("test held pin done");
        power_up(OSC_RCO, 1'b0, 1'b0);
        wait_rel();
        rd(ADDR_CFG2H);
        chk_val(rd_v, {24'h00_0000, CFG2H_RST});
        rd(ADDR_CFG3H);
        chk_val(rd_v, {24'h00_0000, CFG3H_RST});
        rd(ADDR_CFG4L);
        chk_val(rd_v, {24'h00_0000, CFG4L_RST});
        rd(8'h40);
        chk_val({rd_r, rd_v[29:0]}, 32'h8000_0000);
        wr(ADDR_STACK, 8'h00);
        wr(ADDR_EVENT, 8'(1 << EV_POR));
        flags = step(16'h0000, EV_POR);
        wr(ADDR_CAUSE, flags[7:0] | 8'h02);
        flags[1] = 1'b1;
        flag_check();
        for (int i = 0; i < 30; i++) begin
            ev = $urandom_range(7, 0);
            run_mode <= 2'($urandom_range(2, 0));
            {gie_h, gie_l} <= 2'($urandom);
            pc_current <= 21'($urandom) & 21'h1F_FFFE;
            @(posedge sys_clk);
            if (ev == 7) begin
                pin_hold <= 1'b1;
                repeat (12) @(posedge sys_clk);
                pin_hold <= 1'b0;
            end else begin
                wr(ADDR_EVENT, 8'(1 << ev));
                rd(ADDR_PC);
                chk_val(rd_v, {11'h000, exp_pc(ev)});
            end
            while (core_reset !== 1'b0) @(posedge sys_clk);
            flags = step(flags, ev);
            flag_check();
        end
        $display("test cause flags done");
        close_out();
    end
endmodule
`default_nettype wire
